//--- shared/irq_src_pkg.sv
// Package: register map, field layout and types of the interrupt source block
package irq_src_pkg;

  // APB register byte addresses
  localparam logic [7:0] addr_main_ctrl   = 8'h00;
  localparam logic [7:0] addr_second_ctrl = 8'h04;
  localparam logic [7:0] addr_third_ctrl  = 8'h08;
  localparam logic [7:0] addr_prio_ctrl   = 8'h0c;
  localparam logic [7:0] addr_irq_status  = 8'h10;
  localparam logic [7:0] addr_irq_mask    = 8'h14;
  localparam logic [7:0] addr_timer_low   = 8'h18;
  localparam logic [7:0] addr_timer_high  = 8'h1c;

  // Main control field positions
  localparam int main_port_change_flag   = 0;
  localparam int main_ext0_flag          = 1;
  localparam int main_timer_flag         = 2;
  localparam int main_port_change_enable = 3;
  localparam int main_ext0_enable        = 4;
  localparam int main_timer_enable       = 5;
  localparam int main_global_low_enable  = 6;
  localparam int main_global_enable      = 7;

  // Second control field positions
  localparam int second_port_prio   = 0;
  localparam int second_ext3_prio   = 1;
  localparam int second_timer_prio  = 2;
  localparam int second_edge_base   = 3;

  // Third control field positions
  localparam int third_flag_base    = 0;
  localparam int third_enable_base  = 3;
  localparam int third_ext1_prio    = 6;
  localparam int third_ext2_prio    = 7;

  // Own control register fields
  localparam int prio_levels_bit    = 0;
  localparam int timer_16bit_bit    = 1;
  localparam int timer_run_bit      = 2;
  localparam int sleep_bit          = 3;

  // Status and mask layout
  localparam int stat_wake          = 0;
  localparam int stat_high_entry    = 1;
  localparam int stat_low_entry     = 2;

  // Reset values
  localparam logic [7:0] main_reset   = 8'h00;
  localparam logic [7:0] second_reset = 8'hff;
  localparam logic [7:0] third_reset  = 8'hc0;
  localparam logic [7:0] prio_reset   = 8'h00;
  localparam logic [7:0] byte_zero    = 8'h00;
  localparam logic [7:0] byte_max     = 8'hff;

  localparam int num_ext = 4;

  // Core context saved at interrupt entry
  typedef struct packed {
    logic [20:0] return_pc;
    logic [7:0]  working_register;
    logic [7:0]  status_register;
    logic [7:0]  bank_select_register;
  } core_context_t;

  // Request to the core sequencer
  typedef struct packed {
    logic high_request;
    logic low_request;
    logic wake;
  } irq_request_t;

endpackage

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
module pin_sync
  import irq_src_pkg::*;
#(
  parameter int width = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Pins in, settled level and change pulses out
  input  wire logic [width-1:0] pin_async,
  output logic      [width-1:0] level,
  output logic      [width-1:0] rise,
  output logic      [width-1:0] fall
);

  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  // Stage1 feeds only stage2, avoiding metastable fan-out
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once stage2 and stage3 agree on a new value
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          level[i] <= 1'b0;
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end else begin
          rise[i] <= (stage2[i] == stage3[i]) && stage3[i] && !level[i];
          fall[i] <= (stage2[i] == stage3[i]) && !stage3[i] && level[i];
          if (stage2[i] == stage3[i]) begin
            level[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule

//--- rtl/overflow_timer.sv
// 8/16-bit up counter that pulses on wrap to zero
module overflow_timer
  import irq_src_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       run,
  input  wire logic       mode_16bit,
  input  wire logic       load_low,
  input  wire logic       load_high,
  input  wire logic [7:0] load_data,
  // Count and overflow pulse
  output logic      [7:0] timer_zero_count_low,
  output logic      [7:0] timer_zero_count_high,
  output logic            overflow
);

  logic low_max;
  logic high_max;

  assign low_max  = (timer_zero_count_low == byte_max);
  assign high_max = (timer_zero_count_high == byte_max);

  // Software loads win over counting in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_zero_count_low  <= byte_zero;
      timer_zero_count_high <= byte_zero;
      overflow              <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (load_low || load_high) begin
        if (load_low) begin
          timer_zero_count_low <= load_data;
        end
        if (load_high) begin
          timer_zero_count_high <= load_data;
        end
      end else if (run) begin
        timer_zero_count_low <= timer_zero_count_low + 8'h01;
        if (mode_16bit && low_max) begin
          timer_zero_count_high <= timer_zero_count_high + 8'h01;
        end
        // Wrap FFh->00h in 8-bit mode, FFFFh->0000h in 16-bit mode
        overflow <= low_max && (!mode_16bit || high_max);
      end
    end
  end

endmodule

//--- rtl/ext_timer_change_irq_sources.sv
// Interrupt sources: four edge pins, timer overflow, port change, with APB
// Notes on behaviour
// R1: External pins detect edges only; select bit 1 rising, 0 falling.
// R2: A valid edge of selected polarity sets that pin's flag.
// R3: A pin with cleared enable never signals the processor.
// R4: Software clears pin flags in the handler; hardware never clears them.
// R5: Any enabled pin interrupt wakes the processor from power-managed mode.
// R6: After such wake-up, vector branch only when global enable is set.
// R7: Pins one/two/three priority: third ctrl bits 6, 7; second ctrl bit 1.
// R8: Pin zero has no priority bit and is always high priority.
// R9: In 8-bit timer mode, FFh to 00h wrap sets timer flag.
// R10: In 16-bit timer mode, FFFFh to 0000h wrap sets timer flag.
// R11: Timer gated by main ctrl bit 5; priority from second ctrl bit 2.
// R12: Any level change on port bits 7:4 sets main ctrl bit 0.
// R13: Port change gated by main ctrl bit 3; priority second ctrl bit 0.
// R14: Taking an interrupt pushes the return address on the return stack.
// R15: Taking an interrupt copies working, status, bank select to shadow.
// R16: Without fast return, software saves and restores those registers.
// R17: Priority bits act only with priority levels enabled; else one level.
// R18: Flags set regardless of enable; enable gates only the signalling.
module ext_timer_change_irq_sources
  import irq_src_pkg::*;
#(
  parameter int stack_depth = 31
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Port pins: bits 3:0 external interrupt pins, 7:4 change inputs
  input  wire logic [7:0]    port_two_pins,
  // Core sequencer side
  input  wire logic          irq_take,
  input  wire logic          irq_take_high,
  input  wire core_context_t core_context,
  input  wire logic          fast_return,
  output irq_request_t       irq_request,
  output logic               vector_branch,
  output core_context_t      shadow_context,
  output logic [20:0]        stack_top,
  output logic [4:0]         stack_level,
  output logic               stack_overflow,
  // Interrupt to the system
  output logic               irq
);

  logic [7:0] main_irq_control;
  logic [7:0] second_irq_control;
  logic [7:0] third_irq_control;
  logic [7:0] prio_ctrl;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  logic [7:0] pin_level;
  logic [7:0] pin_rise;
  logic [7:0] pin_fall;
  logic       timer_overflow;
  logic [7:0] timer_low;
  logic [7:0] timer_high;

  logic [3:0] ext_pin_irq_flag;
  logic [3:0] ext_pin_irq_enable;
  logic [3:0] edge_polarity_select;
  logic [3:0] ext_pin_edge;
  logic [3:0] ext_prio;
  logic       priority_levels_enable;
  logic       global_irq_enable;
  logic       sleeping;

  logic       apb_write;
  logic       apb_read;
  logic       wr_main;
  logic       wr_second;
  logic       wr_third;
  logic       known_addr;

  logic [3:0] ext_active;
  logic       timer_active;
  logic       change_active;
  logic       any_high;
  logic       any_low;
  logic       any_wake;
  logic       high_entry;
  logic       low_entry;

  logic [20:0] return_stack [stack_depth];

  // Three-flop synchroniser for all eight port pins
  pin_sync #(
    .width(8)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .pin_async(port_two_pins),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // APB strobes: zero wait state, write takes effect at the access edge
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && penable && !pwrite;
  assign wr_main   = apb_write && (paddr == addr_main_ctrl);
  assign wr_second = apb_write && (paddr == addr_second_ctrl);
  assign wr_third  = apb_write && (paddr == addr_third_ctrl);
  assign pready    = 1'b1;

  overflow_timer u_timer (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .run                  (prio_ctrl[timer_run_bit]),
    .mode_16bit           (prio_ctrl[timer_16bit_bit]),
    .load_low             (apb_write && (paddr == addr_timer_low)),
    .load_high            (apb_write && (paddr == addr_timer_high)),
    .load_data            (pwdata[7:0]),
    .timer_zero_count_low (timer_low),
    .timer_zero_count_high(timer_high),
    .overflow             (timer_overflow)
  );

  // Field views of the control registers
  assign edge_polarity_select = second_irq_control[second_edge_base +: 4];
  assign ext_pin_irq_flag = {third_irq_control[third_flag_base +: 3],
                             main_irq_control[main_ext0_flag]};
  assign ext_pin_irq_enable = {third_irq_control[third_enable_base +: 3],
                               main_irq_control[main_ext0_enable]};
  assign priority_levels_enable = prio_ctrl[prio_levels_bit];
  assign global_irq_enable      = main_irq_control[main_global_enable];
  assign sleeping               = prio_ctrl[sleep_bit];

  // Edge of the selected polarity per pin
  genvar i;
  generate
    for (i = 0; i < num_ext; i++) begin : g_edge
      assign ext_pin_edge[i] = edge_polarity_select[i] ? pin_rise[i]
                                                       : pin_fall[i]; // [R1]
    end
  endgenerate

  // Main control: software writes, hardware sets flags; set wins over clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_irq_control <= main_reset;
    end else begin
      if (wr_main) begin
        main_irq_control <= pwdata[7:0];
      end
      if (ext_pin_edge[0]) begin
        main_irq_control[main_ext0_flag] <= 1'b1; // [R2] [R18]
      end
      if (timer_overflow) begin
        main_irq_control[main_timer_flag] <= 1'b1; // [R9] [R10] [R18]
      end
      if (|(pin_rise[7:4] | pin_fall[7:4])) begin
        main_irq_control[main_port_change_flag] <= 1'b1; // [R12] [R18]
      end
    end
  end

  // Second control: edge polarity and priority bits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_irq_control <= second_reset;
    end else if (wr_second) begin
      second_irq_control <= pwdata[7:0];
    end
  end

  // Third control: pin 1-3 flags are only cleared by software writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      third_irq_control <= third_reset;
    end else begin
      if (wr_third) begin
        third_irq_control <= pwdata[7:0];
      end
      for (int k = 1; k < num_ext; k++) begin
        if (ext_pin_edge[k]) begin
          third_irq_control[third_flag_base + k - 1] <= 1'b1; // [R2] [R4]
        end
      end
    end
  end

  // Own control: priority levels, timer mode and run, sleep request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prio_ctrl <= prio_reset;
    end else if (apb_write && (paddr == addr_prio_ctrl)) begin
      prio_ctrl <= pwdata[7:0];
    end else if (any_wake && sleeping) begin
      prio_ctrl[sleep_bit] <= 1'b0; // [R5]
    end
  end

  // Per-source priority; pin zero fixed high
  assign ext_prio[0] = 1'b1; // [R8]
  assign ext_prio[1] = third_irq_control[third_ext1_prio]; // [R7]
  assign ext_prio[2] = third_irq_control[third_ext2_prio]; // [R7]
  assign ext_prio[3] = second_irq_control[second_ext3_prio]; // [R7]

  // Enable gating: flags stand regardless, only signalling is gated
  assign ext_active    = ext_pin_irq_flag & ext_pin_irq_enable; // [R3] [R18]
  assign timer_active  = main_irq_control[main_timer_flag]
                       && main_irq_control[main_timer_enable]; // [R11]
  assign change_active = main_irq_control[main_port_change_flag]
                       && main_irq_control[main_port_change_enable]; // [R13]

  // Priority split only with priority levels enabled
  always_comb begin
    any_high = 1'b0;
    any_low  = 1'b0;
    for (int k = 0; k < num_ext; k++) begin
      if (ext_active[k]) begin
        if (!priority_levels_enable || ext_prio[k]) begin // [R17]
          any_high = 1'b1;
        end else begin
          any_low = 1'b1;
        end
      end
    end
    if (timer_active) begin
      if (!priority_levels_enable
          || second_irq_control[second_timer_prio]) begin // [R11] [R17]
        any_high = 1'b1;
      end else begin
        any_low = 1'b1;
      end
    end
    if (change_active) begin
      if (!priority_levels_enable
          || second_irq_control[second_port_prio]) begin // [R13] [R17]
        any_high = 1'b1;
      end else begin
        any_low = 1'b1;
      end
    end
  end

  // Wake needs enabled source only; vectoring needs the global enable
  assign any_wake   = any_high || any_low; // [R5]
  assign high_entry = any_high && global_irq_enable; // [R6]
  assign low_entry  = any_low && global_irq_enable
                    && (!priority_levels_enable
                        || main_irq_control[main_global_low_enable]);
  assign irq_request.high_request = high_entry;
  assign irq_request.low_request  = low_entry;
  assign irq_request.wake         = any_wake && sleeping; // [R5]
  assign vector_branch            = high_entry || low_entry; // [R6]

  // Fast return shadow: one deep, filled on every entry
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_context <= '0;
    end else if (irq_take) begin
      shadow_context <= core_context; // [R15]
    end
  end

  // Hardware return stack; fast_return pops it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_level    <= 5'h00;
      stack_overflow <= 1'b0;
    end else if (irq_take) begin
      if (stack_level == 5'(stack_depth)) begin
        stack_overflow <= 1'b1;
      end else begin
        stack_level <= stack_level + 5'h01; // [R14]
      end
    end else if (fast_return && (stack_level != 5'h00)) begin
      stack_level <= stack_level - 5'h01;
    end
  end

  // Stack storage needs no reset: level guards every read
  always_ff @(posedge sys_clk) begin
    if (irq_take && (stack_level != 5'(stack_depth))) begin
      return_stack[stack_level] <= core_context.return_pc; // [R14]
    end
  end

  assign stack_top = (stack_level == 5'h00) ? 21'h000000
                   : return_stack[stack_level - 5'h01];

  // Sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= byte_zero;
    end else begin
      if (apb_write && (paddr == addr_irq_status)) begin
        irq_status <= irq_status & ~pwdata[7:0];
      end
      if (irq_request.wake) begin
        irq_status[stat_wake] <= 1'b1;
      end
      if (irq_take && irq_take_high) begin
        irq_status[stat_high_entry] <= 1'b1;
      end
      if (irq_take && !irq_take_high) begin
        irq_status[stat_low_entry] <= 1'b1;
      end
    end
  end

  // Mask register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= byte_zero;
    end else if (apb_write && (paddr == addr_irq_mask)) begin
      irq_mask <= pwdata[7:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read mux; unmapped addresses answer with an error
  assign known_addr = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign pslverr    = psel && penable && !known_addr;

  always_comb begin
    unique case (paddr)
      addr_main_ctrl:   prdata = {24'h000000, main_irq_control};
      addr_second_ctrl: prdata = {24'h000000, second_irq_control};
      addr_third_ctrl:  prdata = {24'h000000, third_irq_control};
      addr_prio_ctrl:   prdata = {24'h000000, prio_ctrl};
      addr_irq_status:  prdata = {24'h000000, irq_status};
      addr_irq_mask:    prdata = {24'h000000, irq_mask};
      addr_timer_low:   prdata = {24'h000000, timer_low};
      addr_timer_high:  prdata = {24'h000000, timer_high};
      default:          prdata = {24'h000000, pin_level};
    endcase
    if (!apb_read) begin
      prdata = 32'h00000000;
    end
  end

endmodule

//--- verif/core_seq_model.sv
// Core sequencer model: takes requests, returns from handlers
module core_seq_model
  import irq_src_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  // Bench controls
  input  wire logic          take_en,
  input  wire logic          ret_en,
  // Block side
  input  wire irq_request_t  irq_request,
  output logic               irq_take,
  output logic               irq_take_high,
  output core_context_t      core_context,
  output logic               fast_return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic          taken;
  logic          returned;
  logic          pending;
  core_context_t saved;
  assign pending = irq_request.high_request || irq_request.low_request;
  // One take per grant window; context moves every cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_take      <= 1'b0;
      irq_take_high <= 1'b0;
      taken         <= 1'b0;
      returned      <= 1'b0;
      fast_return   <= 1'b0;
      core_context  <= '0;
      saved         <= '0;
    end else begin
      irq_take      <= take_en && !taken && pending;
      irq_take_high <= irq_request.high_request;
      taken         <= take_en && (taken || pending);
      returned      <= ret_en;
      fast_return   <= ret_en && !returned;
      core_context  <= core_context + 45'h1_0203_0405;
      // Handler keeps its own copy of the context
      if (irq_take) saved <= core_context;
    end
  end
endmodule

//--- verif/irq_src_monitor.sv
// Checker bound to the interrupt source block
module irq_src_monitor
  import irq_src_pkg::*;
#(
  parameter int stack_depth = 31
) (
  // Clock, reset and bus
  input wire logic          sys_clk,
  input wire logic          reset_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pslverr,
  // Core side
  input wire logic          irq_take,
  input wire logic          fast_return,
  input wire core_context_t core_context,
  input wire irq_request_t  irq_request,
  input wire logic          vector_branch,
  input wire core_context_t shadow_context,
  input wire logic [20:0]   stack_top,
  input wire logic [4:0]    stack_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] main_q;
  logic [7:0] third_q;
  logic [7:0] prio_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Mirror of written enables
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_q  <= main_reset;
      third_q <= third_reset;
      prio_q  <= prio_reset;
    end else if (psel && penable && pwrite) begin
      if (paddr == addr_main_ctrl) main_q <= pwdata[7:0];
      if (paddr == addr_third_ctrl) third_q <= pwdata[7:0];
      if (paddr == addr_prio_ctrl) prio_q <= pwdata[7:0];
    end
  end
  sequence push_s;
    irq_take && !fast_return && stack_level < 5'(stack_depth);
  endsequence
  sequence pop_s;
    fast_return && !irq_take && stack_level != 5'd0;
  endsequence
  push_level_a: assert property (
    push_s |=> stack_level == $past(stack_level) + 5'd1)
    else $error("push level");
  push_top_a: assert property (
    push_s |=> stack_top == $past(core_context.return_pc))
    else $error("push top");
  pop_level_a: assert property (
    pop_s |=> stack_level == $past(stack_level) - 5'd1)
    else $error("pop level");
  shadow_copy_a: assert property (
    irq_take |=> shadow_context == $past(core_context))
    else $error("shadow copy");
  global_gate_a: assert property (
    !main_q[main_global_enable] |-> !irq_request.high_request)
    else $error("global gate");
  source_gate_a: assert property (
    main_q[5:3] == 3'b000 && third_q[5:3] == 3'b000 |-> !vector_branch)
    else $error("source gate");
  one_level_a: assert property (
    !prio_q[prio_levels_bit] |-> !irq_request.low_request)
    else $error("one level");
  unmapped_error_a: assert property (
    psel && penable && paddr >= 8'h20 |-> pslverr)
    else $error("unmapped");
endmodule
bind ext_timer_change_irq_sources irq_src_monitor #(
  .stack_depth(stack_depth)
) monitor (.*);

//--- verif/tb.sv
// Self-checking bench for the interrupt source block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_src_pkg::*;
  logic          sys_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [7:0]    pins = 8'h00;
  logic          take_en = 1'b0;
  logic          ret_en = 1'b0;
  logic [31:0]   prdata, d;
  logic          pready, pslverr, serr, irq, stack_overflow;
  logic          irq_take, irq_take_high, fast_return, vector_branch;
  logic [20:0]   stack_top;
  logic [4:0]    stack_level;
  core_context_t core_context, shadow_context, ctx;
  irq_request_t  irq_request;
  int            errors = 0;
  int            check_count = 0;
  ext_timer_change_irq_sources dut (.*, .port_two_pins(pins));
  core_seq_model core (.*);
  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string n, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // Request held until pready is seen at an edge
  task automatic bus(input logic w, logic [7:0] a, logic [7:0] v);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    d = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  // Bounded poll of one bit; always reads at least once
  task automatic poll(input logic [7:0] a, int b, logic v, string n);
    rd(a);
    for (int i = 0; i < 150 && d[b] !== v; i++) rd(a);
    check(n, v, d[b]);
    if (d[b] !== v) stop_test();
  endtask
  task automatic req(input logic [2:0] e, string n);
    check(n, e, irq_request);
  endtask
  task automatic t_reset();
    logic [7:0] a[6] = '{addr_main_ctrl, addr_second_ctrl, addr_third_ctrl,
                         addr_prio_ctrl, addr_irq_status, addr_irq_mask};
    logic [7:0] r[6] = '{main_reset, second_reset, third_reset,
                         prio_reset, byte_zero, byte_zero};
    foreach (a[i]) begin
      rd(a[i]);
      check("reset value", r[i], d);
    end
  endtask
  // Pin 0 on rising, pin 1 on falling, enables off
  task automatic t_edges();
    wr(addr_second_ctrl, 8'he8);
    pins <= 8'h0f;
    poll(addr_main_ctrl, main_ext0_flag, 1'b1, "pin0");
    pins <= 8'h0d;
    poll(addr_third_ctrl, third_flag_base, 1'b1, "pin1");
    wr(addr_main_ctrl, 8'h00);
    pins <= 8'h0c;
    repeat (10) @(posedge sys_clk);
    rd(addr_main_ctrl);
    check("pin0 fall", 1'h0, d[main_ext0_flag]);
  endtask
  task automatic t_prio();
    wr(addr_prio_ctrl, 8'h01);
    wr(addr_main_ctrl, 8'hc0);
    wr(addr_third_ctrl, 8'h09);
    req(3'b010, "pin1 low");
    wr(addr_third_ctrl, 8'h49);
    req(3'b100, "pin1 high");
    wr(addr_main_ctrl, 8'h40);
    req(3'b000, "no global");
    wr(addr_main_ctrl, 8'hc0);
    wr(addr_third_ctrl, 8'h41);
    req(3'b000, "pin1 off");
    wr(addr_prio_ctrl, 8'h00);
    wr(addr_third_ctrl, 8'h09);
    wr(addr_main_ctrl, 8'h80);
    req(3'b100, "one level");
    wr(addr_third_ctrl, 8'h00);
    wr(addr_prio_ctrl, 8'h01);
    wr(addr_main_ctrl, 8'h50);
    pins <= 8'h0d;
    poll(addr_main_ctrl, main_ext0_flag, 1'b1, "pin0");
    req(3'b000, "pin0 not low");
    wr(addr_main_ctrl, 8'hd2);
    req(3'b100, "pin0 high");
  endtask
  // Entry, shadow, status interrupt and return
  task automatic t_ctx();
    int n = 0;
    take_en <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irq_take !== 1'b1 && n < 20);
    check("take", 1'h1, irq_take);
    ctx = core_context;
    @(posedge sys_clk);
    take_en <= 1'b0;
    check("top", ctx.return_pc, stack_top);
    check("level", 1'h1, stack_level);
    check("shadow", ctx, shadow_context);
    wr(addr_main_ctrl, 8'h00);
    check("masked", 1'h0, irq);
    wr(addr_irq_mask, 8'h02);
    check("irq", 1'h1, irq);
    wr(addr_irq_status, 8'h02);
    check("cleared", 1'h0, irq);
    ret_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ret_en <= 1'b0;
    check("pop", 1'h0, stack_level);
  endtask
  task automatic t_timer();
    wr(addr_timer_low, 8'hf0);
    wr(addr_prio_ctrl, 8'h05);
    poll(addr_main_ctrl, main_timer_flag, 1'b1, "8-bit wrap");
    wr(addr_prio_ctrl, 8'h01);
    wr(addr_main_ctrl, 8'h00);
    wr(addr_timer_high, 8'hfe);
    wr(addr_timer_low, 8'hf8);
    wr(addr_prio_ctrl, 8'h07);
    repeat (40) @(posedge sys_clk);
    rd(addr_main_ctrl);
    check("low byte wrap", 1'h0, d[main_timer_flag]);
    poll(addr_main_ctrl, main_timer_flag, 1'b1, "16-bit wrap");
    wr(addr_prio_ctrl, 8'h01);
    wr(addr_main_ctrl, 8'ha4);
    req(3'b000, "timer no low");
    wr(addr_main_ctrl, 8'he4);
    req(3'b010, "timer low");
    wr(addr_main_ctrl, 8'h00);
  endtask
  task automatic t_change();
    pins <= {4'h2, pins[3:0]};
    poll(addr_main_ctrl, main_port_change_flag, 1'b1, "rise");
    wr(addr_main_ctrl, 8'hc9);
    req(3'b010, "change low");
    wr(addr_main_ctrl, 8'hc1);
    req(3'b000, "change off");
    wr(addr_main_ctrl, 8'h00);
    pins <= {4'h0, pins[3:0]};
    poll(addr_main_ctrl, main_port_change_flag, 1'b1, "fall");
    wr(addr_main_ctrl, 8'h00);
  endtask
  // Pin enabled before sleep wakes; no vector without global
  task automatic t_wake();
    wr(addr_main_ctrl, 8'h10);
    pins <= {pins[7:1], 1'b0};
    repeat (6) @(posedge sys_clk);
    wr(addr_prio_ctrl, 8'h09);
    pins <= {pins[7:1], 1'b1};
    poll(addr_prio_ctrl, sleep_bit, 1'b0, "woken");
    check("no vector", 1'h0, vector_branch);
    rd(addr_irq_status);
    check("wake", 1'h1, d[stat_wake]);
    rd(8'h20);
    check("unmapped", 1'h1, serr);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_edges();
    t_prio();
    t_ctx();
    t_timer();
    t_change();
    t_wake();
    stop_test();
  end
  // Hang guard
  initial begin
    #100us;
    errors++;
    stop_test();
  end
endmodule
